// [pph_core.sv]
// Our own choice: strobed register access.
module pph_core (
    input wire logic clk, // system clock, 200 MHz
    input wire logic rstn, // sync reset, active low
    input wire logic [21:0] addr, // register byte address
    input wire logic [15:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [15:0] rdata, // read data, cycle after rd
    input wire logic n_strobe, // host strobe
    input wire logic n_autofd, // host autofeed
    input wire logic n_selectin, // host select-in
    input wire logic n_init, // host init
    input wire logic [7:0] pd_in, // port data pins in
    output logic [7:0] pd_out, // port data pins out
    output logic pd_oe, // port data drive enable
    output logic busy, // busy to host
    output logic n_ack, // acknowledge to host, active low
    output logic perror, // paper error to host
    output logic select, // select to host
    output logic n_fault // fault to host, active low
);
    typedef pph_pkg::pph_state_e pph_state_e;
    localparam pph_state_e PPH_IDLE = pph_pkg::PPH_IDLE;
    localparam pph_state_e PPH_CW_STBHI = pph_pkg::PPH_CW_STBHI;
    localparam pph_state_e PPH_ACK = pph_pkg::PPH_ACK;
    localparam pph_state_e PPH_EF_BUSY = pph_pkg::PPH_EF_BUSY;
    localparam pph_state_e PPH_ER_ACK = pph_pkg::PPH_ER_ACK;
    localparam pph_state_e PPH_ER_WAIT = pph_pkg::PPH_ER_WAIT;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [4:0] ovr;
        logic [7:0] ackw;
        logic [7:0] ftick;
        logic [7:0] tcnt;
        logic [15:0] ev_en;
        logic [15:0] ev_pnd;
        logic [8:0] data;
        logic [8:0] wdat;
        logic rd_done;
        logic [7:0] cnt;
        logic [7:0] run;
        logic [7:0] rle_byte;
        logic rle_pend;
        logic [7:0] run_len;
        logic [7:0] last_byte;
        logic have_last;
        logic stb_d;
        pph_state_e st;
        logic [15:0] rdata;
        logic [7:0] pd_out;
        logic pd_oe;
        logic busy;
        logic n_ack;
        logic perror;
        logic select;
        logic n_fault;
        logic busy_q;
        logic n_ack_q;
    } pph_core_s;

    pph_core_s r;
    pph_core_s next_r;
    logic tick;
    logic stb_f;
    logic afd_f;
    logic sel_f;
    logic init_f;
    logic [1:0] mode;
    logic ecp;
    logic rle;
    logic stb_fall;
    logic data_rd;
    logic data_wr;
    logic int_busy;
    logic int_nack;

    assign tick = (r.ftick == 8'h00) || (r.tcnt == 8'h00);

    pph_filter u_f_stb (.clk(clk), .rstn(rstn), .pin(n_strobe),
        .en(r.ctrl[pph_pkg::CTRL_FILT]), .tick(tick), .level(stb_f));
    pph_filter u_f_afd (.clk(clk), .rstn(rstn), .pin(n_autofd),
        .en(r.ctrl[pph_pkg::CTRL_FILT]), .tick(tick), .level(afd_f));
    pph_filter u_f_sel (.clk(clk), .rstn(rstn), .pin(n_selectin),
        .en(r.ctrl[pph_pkg::CTRL_FILT]), .tick(tick), .level(sel_f));
    pph_filter u_f_ini (.clk(clk), .rstn(rstn), .pin(n_init),
        .en(r.ctrl[pph_pkg::CTRL_FILT]), .tick(tick), .level(init_f));

    assign mode = r.ctrl[pph_pkg::CTRL_MODE_LO +: 2];
    assign ecp = mode[1];
    assign rle = (mode == pph_pkg::PPH_ECP_RLE);
    assign stb_fall = r.stb_d && !stb_f;
    assign data_rd = rd && (addr == pph_pkg::ADDR_DATA);
    assign data_wr = wr && (addr == pph_pkg::ADDR_DATA);

    always_comb begin
        next_r = r;
        int_busy = r.busy;
        int_nack = r.n_ack;
        next_r.stb_d = stb_f;
        next_r.tcnt = (r.tcnt == 8'h00) ? r.ftick : r.tcnt - 8'h01;
        if (data_rd) begin
            next_r.rd_done = 1'b1;
        end
        // register writes
        if (wr) begin
            if (addr == pph_pkg::ADDR_DATA) begin
                next_r.wdat = wdata[8:0];
            end else if (addr == pph_pkg::ADDR_CTRL) begin
                next_r.ctrl = wdata;
            end else if (addr == pph_pkg::ADDR_OVR) begin
                next_r.ovr = wdata[4:0];
            end else if (addr == pph_pkg::ADDR_ACKW) begin
                next_r.ackw = wdata[7:0];
            end else if (addr == pph_pkg::ADDR_EVEN) begin
                next_r.ev_en = wdata;
            end else if (addr == pph_pkg::ADDR_EVPND) begin
                next_r.ev_pnd = r.ev_pnd & ~wdata; // write one to clear
            end else if (addr == pph_pkg::ADDR_FTICK) begin
                next_r.ftick = wdata[7:0];
            end
        end
        if (stb_fall) begin
            next_r.ev_pnd[pph_pkg::EV_STB_FALL] = 1'b1; // set beats clear
        end
        case (r.st)
            PPH_IDLE: begin
                if (mode == pph_pkg::PPH_COMPAT && stb_fall) begin
                    next_r.data = {afd_f, pd_in};
                    int_busy = 1'b1;
                    next_r.rd_done = 1'b0;
                    next_r.st = PPH_CW_STBHI;
                end else if (ecp && !r.ctrl[pph_pkg::CTRL_DIR] && r.run != 8'h00) begin
                    // replay expanded byte while host stalls on busy
                    next_r.data = {1'b1, r.rle_byte};
                    next_r.run = r.run - 8'h01;
                    next_r.ev_pnd[pph_pkg::EV_DATA] = 1'b1;
                    next_r.rd_done = 1'b0;
                    int_busy = 1'b1;
                    next_r.st = PPH_EF_BUSY;
                end else if (ecp && !r.ctrl[pph_pkg::CTRL_DIR] && stb_fall) begin
                    next_r.rd_done = 1'b0;
                    int_busy = 1'b0;
                    if (rle && !afd_f && !pd_in[pph_pkg::RLE_FLAG]) begin
                        next_r.rle_pend = 1'b1;
                        next_r.run_len = pd_in;
                        int_busy = 1'b1;
                        next_r.rd_done = 1'b1;
                    end else begin
                        next_r.data = {afd_f, pd_in};
                        if (afd_f) begin
                            next_r.ev_pnd[pph_pkg::EV_DATA] = 1'b1;
                        end else if (rle) begin
                            next_r.ev_pnd[pph_pkg::EV_CMD_RLE] = 1'b1;
                        end else begin
                            next_r.ev_pnd[pph_pkg::EV_CMD_NORLE] = 1'b1;
                        end
                        if (rle && afd_f && r.rle_pend) begin
                            next_r.rle_byte = pd_in;
                            next_r.run = r.run_len;
                            next_r.rle_pend = 1'b0;
                        end
                    end
                    next_r.st = PPH_EF_BUSY;
                end else if (ecp && r.ctrl[pph_pkg::CTRL_DIR] && data_wr) begin
                    if (rle && wdata[8] && r.have_last && wdata[7:0] == r.last_byte
                        && r.run_len != 8'h7F) begin
                        // same byte again: extend run, nothing sent
                        next_r.run_len = r.run_len + 8'h01;
                    end else begin
                        if (rle && r.run_len != 8'h00) begin
                            // emit run count, then the new byte
                            next_r.pd_out = r.run_len;
                            int_busy = 1'b0;
                            next_r.wdat = wdata[8:0];
                            next_r.rle_pend = 1'b1;
                        end else begin
                            next_r.pd_out = wdata[7:0];
                            int_busy = wdata[8];
                        end
                        next_r.run_len = 8'h00;
                        int_nack = 1'b0;
                        next_r.st = PPH_ER_ACK;
                    end
                    next_r.last_byte = wdata[7:0];
                    next_r.have_last = wdata[8];
                end else if (!ecp) begin
                    next_r.have_last = 1'b0;
                end
            end
            PPH_CW_STBHI: begin
                if (stb_f && r.rd_done) begin
                    int_nack = 1'b0;
                    next_r.cnt = r.ackw;
                    next_r.st = PPH_ACK;
                end
            end
            PPH_ACK: begin
                if (r.cnt <= 8'h01) begin
                    int_nack = 1'b1;
                    int_busy = 1'b0;
                    next_r.st = PPH_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            PPH_EF_BUSY: begin
                if (r.rd_done || data_rd) begin
                    int_busy = 1'b1;
                end
                // a replayed byte keeps busy until software has taken it
                if (r.busy && stb_f && r.rd_done) begin
                    int_busy = 1'b0;
                    next_r.st = PPH_IDLE;
                end
            end
            PPH_ER_ACK: begin
                if (!afd_f) begin
                    next_r.st = PPH_ER_WAIT;
                end
            end
            PPH_ER_WAIT: begin
                if (afd_f) begin
                    int_nack = 1'b1;
                    if (r.rle_pend) begin
                        next_r.rle_pend = 1'b0;
                        next_r.pd_out = r.wdat[7:0];
                        int_busy = r.wdat[8];
                        int_nack = 1'b0;
                        next_r.st = PPH_ER_ACK;
                    end else begin
                        next_r.st = PPH_IDLE;
                    end
                end
            end
            default: next_r.st = PPH_IDLE;
        endcase
        // software mode: pins follow software only
        if (mode == pph_pkg::PPH_SW) begin
            int_busy = 1'b0;
            int_nack = 1'b1;
            next_r.st = PPH_IDLE;
            if (data_wr) begin
                next_r.pd_out = wdata[7:0];
            end
        end
        // busy override halts compat handshake in idle
        if (r.ovr[pph_pkg::OVR_BUSY] && mode == pph_pkg::PPH_COMPAT && r.st == PPH_IDLE) begin
            next_r.st = PPH_IDLE;
            next_r.data = r.data;
            int_busy = r.busy;
        end
        next_r.busy = int_busy;
        next_r.n_ack = int_nack;
        next_r.pd_oe = r.ctrl[pph_pkg::CTRL_DIR];
        if (data_wr && r.ctrl[pph_pkg::CTRL_DIR] && !ecp) begin
            next_r.pd_out = wdata[7:0];
            next_r.busy = wdata[8];
        end
        next_r.perror = r.ovr[pph_pkg::OVR_PERR];
        next_r.select = r.ovr[pph_pkg::OVR_SEL];
        next_r.n_fault = !r.ovr[pph_pkg::OVR_NFAULT];
        // pins come from flops; the busy and ack overrides reach them on the same edge as the register write
        next_r.busy_q = next_r.busy || next_r.ovr[pph_pkg::OVR_BUSY];
        next_r.n_ack_q = next_r.n_ack && !next_r.ovr[pph_pkg::OVR_NACK];
        // read mux
        next_r.rdata = 16'h0000;
        if (rd) begin
            if (addr == pph_pkg::ADDR_DATA) begin
                next_r.rdata = {7'h00, r.data};
            end else if (addr == pph_pkg::ADDR_CTRL) begin
                next_r.rdata = r.ctrl;
            end else if (addr == pph_pkg::ADDR_OVR) begin
                next_r.rdata = {11'h000, r.ovr};
            end else if (addr == pph_pkg::ADDR_STAT) begin
                next_r.rdata = {10'h000, init_f, afd_f, stb_f, sel_f,
                    r.n_ack && !r.ovr[pph_pkg::OVR_NACK], r.busy || r.ovr[pph_pkg::OVR_BUSY]};
            end else if (addr == pph_pkg::ADDR_ACKW) begin
                next_r.rdata = {8'h00, r.ackw};
            end else if (addr == pph_pkg::ADDR_EVEN) begin
                next_r.rdata = r.ev_en;
            end else if (addr == pph_pkg::ADDR_EVPND) begin
                next_r.rdata = r.ev_pnd;
            end else if (addr == pph_pkg::ADDR_FTICK) begin
                next_r.rdata = {8'h00, r.ftick};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= '0;
            r.ctrl <= pph_pkg::CTRL_RST;
            r.ovr <= pph_pkg::OVR_RST;
            r.ackw <= pph_pkg::ACKW_RST;
            r.ftick <= pph_pkg::FTICK_RST;
            r.data <= pph_pkg::DATA_RST;
            r.stb_d <= 1'b1;
            r.st <= PPH_IDLE;
            r.n_ack <= 1'b1;
            r.n_fault <= 1'b1;
            r.busy_q <= 1'b1;
            r.n_ack_q <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign pd_out = r.pd_out;
    assign pd_oe = r.pd_oe;
    assign busy = r.busy_q;
    assign n_ack = r.n_ack_q;
    assign perror = r.perror;
    assign select = r.select;
    assign n_fault = r.n_fault;

    a_ack_width: assert property (@(posedge clk) disable iff (!rstn)
        (r.st == PPH_CW_STBHI && next_r.st == PPH_ACK) |=> !r.n_ack [*1] ##0
        (r.cnt == r.ackw)) else $error("ack width count not loaded");
    a_compat_busy: assert property (@(posedge clk) disable iff (!rstn)
        (mode == pph_pkg::PPH_COMPAT && r.st == PPH_IDLE && stb_fall
         && !r.ovr[pph_pkg::OVR_BUSY]) |=> r.busy && r.data[7:0] == $past(pd_in))
        else $error("busy or capture missing after strobe");
    a_ecp_cmd_flag: assert property (@(posedge clk) disable iff (!rstn)
        (mode == pph_pkg::PPH_ECP && r.st == PPH_IDLE && !r.ctrl[pph_pkg::CTRL_DIR]
         && r.run == 8'h00 && stb_fall && !afd_f) |=> r.ev_pnd[pph_pkg::EV_CMD_NORLE])
        else $error("command flag not set");
    a_rev_nack: assert property (@(posedge clk) disable iff (!rstn)
        (mode == pph_pkg::PPH_ECP && r.ctrl[pph_pkg::CTRL_DIR] && r.st == PPH_IDLE
         && data_wr) |=> !r.n_ack && r.busy == $past(wdata[8]))
        else $error("reverse write handshake wrong");
    a_sw_quiet: assert property (@(posedge clk) disable iff (!rstn)
        (mode == pph_pkg::PPH_SW) |=> r.st == PPH_IDLE) else $error("handshake in sw mode");
    a_ef_release: assert property (@(posedge clk) disable iff (!rstn)
        (r.st == PPH_EF_BUSY && r.busy && stb_f && r.rd_done) |=> !r.busy && r.st == PPH_IDLE)
        else $error("forward busy not released");
    a_replay_hold: assert property (@(posedge clk) disable iff (!rstn)
        (r.st == PPH_EF_BUSY && r.busy && !r.rd_done && !data_rd) |=> r.st == PPH_EF_BUSY)
        else $error("replayed byte released before read");
    c_rle_replay: cover property (@(posedge clk) r.st == PPH_EF_BUSY && r.run != 8'h00);
    c_rev_rle: cover property (@(posedge clk) r.st == PPH_ER_ACK && rle);
    c_compat: cover property (@(posedge clk) r.st == PPH_ACK);
    c_ecp_fwd: cover property (@(posedge clk) r.st == PPH_EF_BUSY && mode == pph_pkg::PPH_ECP);
    c_ecp_rev: cover property (@(posedge clk) r.st == PPH_ER_WAIT);
endmodule

// [pph_pkg.sv]
package pph_pkg;
    // register byte addresses; data/command sits at its printed address
    localparam logic [21:0] ADDR_DATA = 22'h3F0060;
    localparam logic [21:0] ADDR_CTRL = 22'h3F0061;
    localparam logic [21:0] ADDR_OVR = 22'h3F0062;
    localparam logic [21:0] ADDR_STAT = 22'h3F0063;
    localparam logic [21:0] ADDR_ACKW = 22'h3F0064;
    localparam logic [21:0] ADDR_EVEN = 22'h3F0065;
    localparam logic [21:0] ADDR_EVPND = 22'h3F0066;
    localparam logic [21:0] ADDR_FTICK = 22'h3F0067;
    // control register fields
    localparam int CTRL_MODE_LO = 4;
    localparam int CTRL_FILT = 2;
    localparam int CTRL_DIR = 7;
    // pin override fields
    localparam int OVR_NACK = 4;
    localparam int OVR_BUSY = 3;
    localparam int OVR_PERR = 2;
    localparam int OVR_SEL = 1;
    localparam int OVR_NFAULT = 0;
    // event pending fields
    localparam int EV_CMD_NORLE = 8;
    localparam int EV_CMD_RLE = 9;
    localparam int EV_DATA = 0;
    localparam int EV_STB_FALL = 1;
    // reset values
    localparam logic [8:0] DATA_RST = 9'h100;
    localparam logic [15:0] CTRL_RST = 16'h0004;
    localparam logic [4:0] OVR_RST = 5'h08;
    localparam logic [7:0] ACKW_RST = 8'h04;
    localparam logic [7:0] FTICK_RST = 8'h00;
    // filter stability length in samples
    localparam logic [1:0] FILT_LEN = 2'h3;
    // rle: command bytes with bit 7 low carry a run length
    localparam int RLE_FLAG = 7;

    typedef enum logic [1:0] {PPH_SW, PPH_COMPAT, PPH_ECP, PPH_ECP_RLE} pph_mode_e;
    typedef enum logic [2:0] {
        PPH_IDLE, PPH_CW_READ, PPH_CW_STBHI, PPH_ACK, PPH_EF_BUSY, PPH_ER_ACK, PPH_ER_WAIT
    } pph_state_e;
endpackage

// [pph_filter.sv]
// one host input: synchroniser, optional 3-sample stability filter
module pph_filter (
    input wire logic clk, // system clock
    input wire logic rstn, // sync reset, active low
    input wire logic pin, // raw host input
    input wire logic en, // filter enable
    input wire logic tick, // sampling tick
    output logic level // clean level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [1:0] cnt;
        logic lvl;
    } pph_flt_s;
    pph_flt_s r;
    pph_flt_s next_r;
    always_comb begin
        next_r = r;
        next_r.s1 = pin;
        next_r.s2 = r.s1;
        if (!en) begin
            next_r.lvl = r.s2;
            next_r.cnt = 2'h0;
        end else if (tick) begin
            if (r.s2 == r.lvl) begin
                next_r.cnt = 2'h0;
            end else if (r.cnt + 2'h1 >= pph_pkg::FILT_LEN) begin
                next_r.lvl = r.s2;
                next_r.cnt = 2'h0;
            end else begin
                next_r.cnt = r.cnt + 2'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= '{s1: 1'b1, s2: 1'b1, cnt: 2'h0, lvl: 1'b1};
        end else begin
            r <= next_r;
        end
    end
    assign level = r.lvl;
endmodule

// [pph_host.sv]
// host side of the port: forward bytes, glitches, reverse acknowledge
module pph_host (
    input wire logic clk, // system clock
    input wire logic busy, // busy from device
    input wire logic n_ack, // acknowledge from device
    input wire logic rev, // reverse phase active
    output logic n_strobe, // strobe to device
    output logic n_autofd, // autofeed to device
    output logic [7:0] pd // data driven by host
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        n_strobe = 1'b1;
        n_autofd = 1'b1;
        pd = 8'h00;
    end
    // forward byte; ecp waits for busy, bounded so a dead device cannot hang us
    task automatic fwd(input logic [8:0] v, input bit ecp);
        int i;
        @(posedge clk);
        pd <= v[7:0];
        n_autofd <= v[8];
        repeat (3) @(posedge clk);
        n_strobe <= 1'b0;
        if (ecp) begin
            for (i = 0; i < 200 && busy !== 1'b1; i++) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        n_strobe <= 1'b1;
        repeat (8) @(posedge clk);
        pd <= ~v[7:0];
        n_autofd <= 1'b1;
    endtask
    task automatic glitch(input int n);
        @(posedge clk);
        n_strobe <= 1'b0;
        repeat (n) @(posedge clk);
        n_strobe <= 1'b1;
        repeat (12) @(posedge clk);
    endtask
    // reverse: autofeed rests low, goes high a while after ack falls
    initial forever begin
        int i;
        @(posedge clk);
        if (rev && n_ack && n_autofd) n_autofd <= 1'b0;
        if (rev && !n_ack) begin
            repeat (8) @(posedge clk);
            n_autofd <= 1'b1;
            for (i = 0; i < 200 && n_ack !== 1'b1; i++) @(posedge clk);
            repeat (4) @(posedge clk);
            n_autofd <= 1'b0;
        end
    end
endmodule

// [tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, wr, rd, n_strobe, n_autofd, n_selectin, n_init, rev;
    logic [21:0] addr;
    logic [15:0] wdata, rdata, d;
    logic [7:0] pd_in, pd_out, host_pd, b;
    logic pd_oe, busy, n_ack, perror, select, n_fault;
    logic [8:0] v;
    logic [31:0] seed;
    int n_errors, checked, n, k;
    assign pd_in = pd_oe ? pd_out : host_pd;
    pph_core i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .n_strobe(n_strobe), .n_autofd(n_autofd), .n_selectin(n_selectin),
        .n_init(n_init), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .busy(busy),
        .n_ack(n_ack), .perror(perror), .select(select), .n_fault(n_fault));
    pph_host i_host (.clk(clk), .busy(busy), .n_ack(n_ack), .rev(rev), .n_strobe(n_strobe),
        .n_autofd(n_autofd), .pd(host_pd));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] cap_val(input logic [8:0] x);
        return {7'h00, x};
    endfunction
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [21:0] a, input logic [15:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [21:0] a, output logic [15:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 x = rdata;
    endtask
    // counts edges until n_ack reaches lvl; a stuck ack ends the run
    task automatic wait_ack(input logic lvl, output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1 c++;
        end while (n_ack !== lvl && c < 300);
        if (c >= 300) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic ecp_fwd(input logic [8:0] x);
        fork
            i_host.fwd(x, 1'b1);
            begin
                repeat (20) @(posedge clk);
                rd_reg(pph_pkg::ADDR_DATA, d);
                chk(d, cap_val(x));
                repeat (3) @(posedge clk);
                #1 chk({15'h0, busy}, 16'h0001);
            end
        join
        #1 chk({15'h0, busy}, 16'h0000);
    endtask
    initial begin
        {rstn, wr, rd, rev, addr, wdata} = '0;
        n_selectin = 1'b1;
        n_init = 1'b1;
        seed = 32'h569BD23A;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(pph_pkg::ADDR_DATA, d);
        chk(d, 16'h0100);
        chk({14'h0, busy, n_ack}, 16'h0003);
        rd_reg(22'h3F0070, d);
        chk(d, 16'h0000);
        n_init <= 1'b0;
        repeat (10) @(posedge clk);
        rd_reg(pph_pkg::ADDR_STAT, d);
        chk({15'h0, d[5]}, 16'h0000);
        n_init <= 1'b1;
        // filter on from reset: a two-sample glitch must vanish, four must pass
        i_host.glitch(2);
        rd_reg(pph_pkg::ADDR_EVPND, d);
        chk({15'h0, d[pph_pkg::EV_STB_FALL]}, 16'h0000);
        i_host.glitch(4);
        rd_reg(pph_pkg::ADDR_EVPND, d);
        chk({15'h0, d[pph_pkg::EV_STB_FALL]}, 16'h0001);
        wr_reg(pph_pkg::ADDR_EVPND, 16'h0303);
        wr_reg(pph_pkg::ADDR_CTRL, 16'h0000);
        i_host.glitch(1);
        rd_reg(pph_pkg::ADDR_EVPND, d);
        chk({15'h0, d[pph_pkg::EV_STB_FALL]}, 16'h0001);
        wr_reg(pph_pkg::ADDR_CTRL, 16'h0014);
        wr_reg(pph_pkg::ADDR_OVR, 16'h0000);
        for (k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            b = seed[7:0];
            wr_reg(pph_pkg::ADDR_ACKW, {8'h00, 8'h02 + {5'h0, seed[10:8]}});
            i_host.fwd({1'b1, b}, 1'b0);
            chk({15'h0, busy}, 16'h0001);
            rd_reg(pph_pkg::ADDR_DATA, d);
            chk({8'h00, d[7:0]}, {8'h00, b});
            wait_ack(1'b0, n);
            wait_ack(1'b1, n);
            chk(16'(n), {8'h00, 8'h02 + {5'h0, seed[10:8]}});
            chk({15'h0, busy}, 16'h0000);
        end
        wr_reg(pph_pkg::ADDR_CTRL, 16'h0024);
        wr_reg(pph_pkg::ADDR_EVPND, 16'h0303);
        seed = lfsr(seed);
        ecp_fwd({1'b0, seed[7:0]});
        rd_reg(pph_pkg::ADDR_EVPND, d);
        chk({15'h0, d[pph_pkg::EV_CMD_NORLE]}, 16'h0001);
        ecp_fwd({1'b1, seed[15:8]});
        // run length: count of 2 expands the next byte into three reads
        wr_reg(pph_pkg::ADDR_CTRL, 16'h0034);
        wr_reg(pph_pkg::ADDR_EVPND, 16'h0303);
        i_host.fwd({1'b0, 8'h02}, 1'b1);
        fork
            i_host.fwd({1'b1, seed[23:16]}, 1'b1);
            for (k = 0; k < 3; k++) begin
                repeat (20) @(posedge clk);
                rd_reg(pph_pkg::ADDR_DATA, d);
                chk({8'h00, d[7:0]}, {8'h00, seed[23:16]});
            end
        join
        rd_reg(pph_pkg::ADDR_EVPND, d);
        chk({15'h0, d[pph_pkg::EV_CMD_RLE]}, 16'h0000);
        ecp_fwd(9'h085);
        rd_reg(pph_pkg::ADDR_EVPND, d);
        chk({15'h0, d[pph_pkg::EV_CMD_RLE]}, 16'h0001);
        wr_reg(pph_pkg::ADDR_CTRL, 16'h00A4);
        rev <= 1'b1;
        repeat (12) @(posedge clk);
        for (k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            v = {k[0], seed[7:0]};
            wr_reg(pph_pkg::ADDR_DATA, cap_val(v));
            repeat (2) @(posedge clk);
            #1 chk({7'h00, pd_oe, pd_out}, {8'h01, v[7:0]});
            chk({15'h0, busy}, {15'h0, v[8]});
            wait_ack(1'b0, n);
            wait_ack(1'b1, n);
            chk({15'h0, n_autofd}, 16'h0001);
            repeat (10) @(posedge clk);
        end
        stop_test();
    end
endmodule
